// ---- include/mic_pkg.sv ----
// Constants shared by the interrupt controller files
package mic_pkg;

	// ---------------------------------------------------------------
	// Sources, in priority order (index 0 is highest)
	// ---------------------------------------------------------------
	localparam int unsigned NUM_SRC  = 11;
	localparam int unsigned SRC_EXT0 = 0;
	localparam int unsigned SRC_OCP  = 1;
	localparam int unsigned SRC_EXT1 = 2;
	localparam int unsigned SRC_MF0  = 3;
	localparam int unsigned SRC_MF1  = 4;
	localparam int unsigned SRC_TB0  = 5;
	localparam int unsigned SRC_TB1  = 6;
	localparam int unsigned SRC_IIC  = 7;
	localparam int unsigned SRC_ADC  = 8;
	localparam int unsigned SRC_LVD  = 9;
	localparam int unsigned SRC_DMEM = 10;
	localparam int unsigned NUM_TMR  = 2;

	// ---------------------------------------------------------------
	// Vector table
	// ---------------------------------------------------------------
	localparam logic [7:0] VEC_BASE = 8'h04;
	localparam logic [7:0] VEC_LAST = 8'h2C;
	localparam logic [7:0] VEC_MF0  = 8'h10;
	localparam int unsigned PC_W    = 13;

	// ---------------------------------------------------------------
	// Register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL0 = 8'h00;
	localparam logic [7:0] OFS_CTRL1 = 8'h04;
	localparam logic [7:0] OFS_CTRL2 = 8'h08;
	localparam logic [7:0] OFS_TMR0  = 8'h0C;
	localparam logic [7:0] OFS_TMR1  = 8'h10;
	localparam logic [7:0] OFS_STAT  = 8'h14;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int unsigned CTRL0_GIE     = 0;
	localparam int unsigned CTRL0_EN_LSB  = 1;
	localparam int unsigned CTRL0_FLG_LSB = 4;
	localparam int unsigned CTRL0_NUM     = 3;
	localparam int unsigned CTRL_EN_LSB   = 0;
	localparam int unsigned CTRL_FLG_LSB  = 4;
	localparam int unsigned CTRL_NUM      = 4;
	localparam int unsigned MFI_P_EN      = 0;
	localparam int unsigned MFI_A_EN      = 1;
	localparam int unsigned MFI_P_FLAG    = 4;
	localparam int unsigned MFI_A_FLAG    = 5;
	localparam int unsigned STAT_WAKE     = 8;
	localparam int unsigned STAT_ACK      = 9;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0]  RST_REG   = 8'h00;
	localparam logic [31:0] RST_RDATA = 32'h0000_0000;

endpackage

// ---- hw/mic_prio_enc.sv ----
// Fixed priority encoder over pending requests
`timescale 1ns/1ps

module mic_prio_enc (
	input  wire logic [mic_pkg::NUM_SRC-1:0] pending,
	output logic                             valid,
	output logic [3:0]                       idx
);

	// Scan from lowest priority upward so the highest one is left last
	always_comb begin
		valid = 1'b0;
		idx   = 4'h0;
		for (int i = mic_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (pending[i]) begin
				valid = 1'b1;
				idx   = 4'(i);
			end
		end
	end

endmodule

// ---- hw/mic_irq_ctrl.sv ----
// Interrupt request, enable and vectoring logic with AHB-Lite registers
//
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/1ps

// Contract
// [RULE_01] Timer0 control: A flag bit5, P flag bit4, A enable bit1, P enable bit0.
// [RULE_02] Timer1 control uses the same layout as timer0.
// [RULE_03] Bits 7:6 and 3:2 of both timer controls read zero.
// [RULE_04] Any source event sets its flag regardless of enables.
// [RULE_05] Flag without its enable stays set but causes no jump.
// [RULE_06] Global enable low blocks acceptance from every source.
// [RULE_07] Acceptance pushes the next-instruction address, then loads the vector.
// [RULE_08] Return-from-interrupt pops the saved address and resumes there.
// [RULE_09] Servicing clears the global enable so nothing nests.
// [RULE_10] Requests arriving while blocked keep their flags for later.
// [RULE_11] No acknowledge while the stack is full.
// [RULE_12] Software may set global enable inside a routine to allow nesting.
// [RULE_13] Simultaneous requests accepted by fixed priority, pin 0 highest.
// [RULE_14] Vectors 04H to 2CH in priority order, step four.
// [RULE_15] A flag newly set during sleep or idle wakes the device.
// [RULE_16] Software sets a flag beforehand to avoid an unwanted wake.
// [RULE_17] Multi-function flags bits 5:4, enables bits 1:0, reset zero.
// [RULE_18] Servicing a direct request clears its flag with the global enable.
// [RULE_19] Multi-function request is the OR of enabled timer compare flags.
// [RULE_20] Timer compare flags are not cleared on servicing.
module mic_irq_ctrl (
	input  wire logic                        clk,
	input  wire logic                        nrst,
	input  wire logic                        hsel,
	input  wire logic [31:0]                 haddr,
	input  wire logic [1:0]                  htrans,
	input  wire logic                        hwrite,
	input  wire logic [2:0]                  hsize,
	input  wire logic [31:0]                 hwdata,
	input  wire logic                        hready,
	output logic [31:0]                      hrdata,
	output logic                             hreadyout,
	output logic                             hresp,
	input  wire logic [8:0]                  srcEvent,
	input  wire logic [3:0]                  tmrEvent,
	input  wire logic [mic_pkg::PC_W-1:0]    nextPc,
	input  wire logic                        cpuReady,
	input  wire logic                        stackFull,
	input  wire logic                        returnExec,
	input  wire logic                        sleepMode,
	output logic                             irqTake,
	output logic [7:0]                       irqVector,
	output logic                             pushReq,
	output logic [mic_pkg::PC_W-1:0]         pushPc,
	output logic                             popReq,
	output logic                             wakeReq
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef enum logic [0:0] {SEQ_IDLE, SEQ_ACK} mic_seq_t;

	typedef struct packed {
		mic_seq_t                     seq;
		logic                         gie;
		logic [mic_pkg::NUM_SRC-1:0]  flag;
		logic [mic_pkg::NUM_SRC-1:0]  en;
		logic [3:0]                   tmrFlag;
		logic [3:0]                   tmrEn;
		logic                         dpWrite;
		logic [7:0]                   dpAddr;
		logic [31:0]                  hrdata;
		logic                         hreadyout;
		logic                         hresp;
		logic                         irqTake;
		logic [7:0]                   irqVector;
		logic                         pushReq;
		logic [mic_pkg::PC_W-1:0]     pushPc;
		logic                         popReq;
		logic                         wakeReq;
		logic [7:0]                   lastVector;
	} mic_state_t;

	mic_state_t                   s;
	mic_state_t                   next_s;
	logic [mic_pkg::NUM_SRC-1:0]  pending;
	logic                         winValid;
	logic [3:0]                   winIdx;
	logic                         addrPhase;
	logic                         addrMapped;
	logic                         rdMfiReq;

	// ---------------------------------------------------------------
	// Priority resolution
	// ---------------------------------------------------------------
	assign pending = s.flag & s.en; // [RULE_05]

	mic_prio_enc u_prio (
		.pending (pending),
		.valid   (winValid),
		.idx     (winIdx)
	);

	assign addrPhase  = hsel && hready && htrans[1];
	assign addrMapped = (haddr[31:8] == 24'h00_0000) && (haddr[7:0] <= mic_pkg::OFS_STAT)
		&& (haddr[1:0] == 2'b00);
	assign rdMfiReq   = addrPhase && !hwrite
		&& (haddr[7:0] == mic_pkg::OFS_TMR0 || haddr[7:0] == mic_pkg::OFS_TMR1);

	// ---------------------------------------------------------------
	// Register read view
	// ---------------------------------------------------------------
	function automatic logic [31:0] read_reg(input logic [7:0] a, input mic_state_t st);
		logic [31:0] r;
		r = mic_pkg::RST_RDATA;
		case (a)
			mic_pkg::OFS_CTRL0: begin
				r[mic_pkg::CTRL0_GIE] = st.gie;
				for (int i = 0; i < mic_pkg::CTRL0_NUM; i++) begin
					r[mic_pkg::CTRL0_EN_LSB + i]  = st.en[mic_pkg::SRC_EXT0 + i];
					r[mic_pkg::CTRL0_FLG_LSB + i] = st.flag[mic_pkg::SRC_EXT0 + i];
				end
			end
			mic_pkg::OFS_CTRL1: begin
				for (int i = 0; i < mic_pkg::CTRL_NUM; i++) begin
					r[mic_pkg::CTRL_EN_LSB + i]  = st.en[mic_pkg::SRC_MF0 + i]; // [RULE_17]
					r[mic_pkg::CTRL_FLG_LSB + i] = st.flag[mic_pkg::SRC_MF0 + i];
				end
			end
			mic_pkg::OFS_CTRL2: begin
				for (int i = 0; i < mic_pkg::CTRL_NUM; i++) begin
					r[mic_pkg::CTRL_EN_LSB + i]  = st.en[mic_pkg::SRC_IIC + i];
					r[mic_pkg::CTRL_FLG_LSB + i] = st.flag[mic_pkg::SRC_IIC + i];
				end
			end
			mic_pkg::OFS_TMR0, mic_pkg::OFS_TMR1: begin
				// Unimplemented bits stay at the zero default [RULE_03]
				for (int k = 0; k < mic_pkg::NUM_TMR; k++) begin
					if (a == ((k == 0) ? mic_pkg::OFS_TMR0 : mic_pkg::OFS_TMR1)) begin
						r[mic_pkg::MFI_P_EN]   = st.tmrEn[2*k];     // [RULE_01] [RULE_02]
						r[mic_pkg::MFI_A_EN]   = st.tmrEn[2*k+1];
						r[mic_pkg::MFI_P_FLAG] = st.tmrFlag[2*k];
						r[mic_pkg::MFI_A_FLAG] = st.tmrFlag[2*k+1];
					end
				end
			end
			mic_pkg::OFS_STAT: begin
				r[7:0]               = st.lastVector;
				r[mic_pkg::STAT_WAKE] = st.wakeReq;
				r[mic_pkg::STAT_ACK]  = (st.seq == SEQ_ACK);
			end
			default: begin
				r = mic_pkg::RST_RDATA;
			end
		endcase
		return r;
	endfunction

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		logic [7:0]                  wd;
		logic [mic_pkg::NUM_SRC-1:0] evt;
		logic [1:0]                  mfSet;
		logic [14:0]                 newSet;
		wd     = hwdata[7:0];
		evt    = '0;
		mfSet  = 2'b00;
		newSet = '0;
		next_s = s;
		next_s.hreadyout = 1'b1;
		next_s.hresp     = 1'b0;
		next_s.irqTake   = 1'b0;
		next_s.pushReq   = 1'b0;
		next_s.popReq    = 1'b0;

		// Software write in the data phase
		if (s.dpWrite) begin
			case (s.dpAddr)
				mic_pkg::OFS_CTRL0: begin
					next_s.gie = wd[mic_pkg::CTRL0_GIE]; // [RULE_12]
					for (int i = 0; i < mic_pkg::CTRL0_NUM; i++) begin
						next_s.en[mic_pkg::SRC_EXT0 + i]   = wd[mic_pkg::CTRL0_EN_LSB + i];
						next_s.flag[mic_pkg::SRC_EXT0 + i] = wd[mic_pkg::CTRL0_FLG_LSB + i];
					end
				end
				mic_pkg::OFS_CTRL1: begin
					for (int i = 0; i < mic_pkg::CTRL_NUM; i++) begin
						next_s.en[mic_pkg::SRC_MF0 + i]   = wd[mic_pkg::CTRL_EN_LSB + i];
						next_s.flag[mic_pkg::SRC_MF0 + i] = wd[mic_pkg::CTRL_FLG_LSB + i];
					end
				end
				mic_pkg::OFS_CTRL2: begin
					for (int i = 0; i < mic_pkg::CTRL_NUM; i++) begin
						next_s.en[mic_pkg::SRC_IIC + i]   = wd[mic_pkg::CTRL_EN_LSB + i];
						next_s.flag[mic_pkg::SRC_IIC + i] = wd[mic_pkg::CTRL_FLG_LSB + i];
					end
				end
				mic_pkg::OFS_TMR0, mic_pkg::OFS_TMR1: begin
					for (int k = 0; k < mic_pkg::NUM_TMR; k++) begin
						if (s.dpAddr == ((k == 0) ? mic_pkg::OFS_TMR0 : mic_pkg::OFS_TMR1)) begin
							next_s.tmrEn[2*k]     = wd[mic_pkg::MFI_P_EN];   // [RULE_01] [RULE_02]
							next_s.tmrEn[2*k+1]   = wd[mic_pkg::MFI_A_EN];
							next_s.tmrFlag[2*k]   = wd[mic_pkg::MFI_P_FLAG];
							next_s.tmrFlag[2*k+1] = wd[mic_pkg::MFI_A_FLAG];
						end
					end
				end
				default: begin
					next_s.dpAddr = s.dpAddr;
				end
			endcase
		end

		// Return restores the saved address and re-arms acceptance
		if (returnExec) begin
			next_s.popReq = 1'b1; // [RULE_08]
			next_s.gie    = 1'b1;
		end

		// Acceptance; clearing the enable here beats any software set this cycle
		case (s.seq)
			SEQ_IDLE: begin
				if (s.gie && winValid && !stackFull && cpuReady) begin // [RULE_06] [RULE_11]
					next_s.seq        = SEQ_ACK;
					next_s.gie        = 1'b0;                          // [RULE_09]
					next_s.flag[winIdx] = 1'b0;                        // [RULE_18]
					next_s.irqTake    = 1'b1;
					next_s.irqVector  = mic_pkg::VEC_BASE + {2'b00, winIdx, 2'b00}; // [RULE_13] [RULE_14]
					next_s.lastVector = mic_pkg::VEC_BASE + {2'b00, winIdx, 2'b00};
					next_s.pushReq    = 1'b1;                          // [RULE_07]
					next_s.pushPc     = nextPc;
				end
			end
			SEQ_ACK: begin
				// One idle cycle lets the core commit the push before rearbitration
				next_s.seq = SEQ_IDLE;
			end
			default: begin
				next_s.seq = SEQ_IDLE;
			end
		endcase

		// Events set after every clear so a same-cycle set is never lost
		next_s.tmrFlag = next_s.tmrFlag | tmrEvent; // [RULE_04] [RULE_20]
		for (int k = 0; k < mic_pkg::NUM_TMR; k++) begin
			mfSet[k] = |(next_s.tmrFlag[2*k +: 2] & next_s.tmrEn[2*k +: 2]); // [RULE_19]
		end
		evt[mic_pkg::SRC_EXT0] = srcEvent[0];
		evt[mic_pkg::SRC_OCP]  = srcEvent[1];
		evt[mic_pkg::SRC_EXT1] = srcEvent[2];
		evt[mic_pkg::SRC_MF0]  = mfSet[0];
		evt[mic_pkg::SRC_MF1]  = mfSet[1];
		evt[mic_pkg::SRC_TB0]  = srcEvent[3];
		evt[mic_pkg::SRC_TB1]  = srcEvent[4];
		evt[mic_pkg::SRC_IIC]  = srcEvent[5];
		evt[mic_pkg::SRC_ADC]  = srcEvent[6];
		evt[mic_pkg::SRC_LVD]  = srcEvent[7];
		evt[mic_pkg::SRC_DMEM] = srcEvent[8];
		next_s.flag = next_s.flag | evt; // [RULE_04] [RULE_10]

		// Only a 0-to-1 flag change wakes; an already set flag does not [RULE_16]
		newSet = {next_s.flag, next_s.tmrFlag} & ~{s.flag, s.tmrFlag};
		if (!sleepMode) begin
			next_s.wakeReq = 1'b0;
		end else if (|newSet) begin
			next_s.wakeReq = 1'b1; // [RULE_15]
		end

		// Address phase; reads see this cycle's updates, so no wait state
		if (addrPhase && addrMapped) begin
			next_s.dpWrite = hwrite;
			next_s.dpAddr  = haddr[7:0];
			if (!hwrite) begin
				next_s.hrdata = read_reg(haddr[7:0], next_s);
			end
		end else begin
			next_s.dpWrite = 1'b0;
			if (addrPhase) begin
				next_s.hrdata = mic_pkg::RST_RDATA;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s <= '0; // [RULE_17]
		end else begin
			s <= next_s;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign hrdata    = s.hrdata;
	assign hreadyout = s.hreadyout;
	assign hresp     = s.hresp;
	assign irqTake   = s.irqTake;
	assign irqVector = s.irqVector;
	assign pushReq   = s.pushReq;
	assign pushPc    = s.pushPc;
	assign popReq    = s.popReq;
	assign wakeReq   = s.wakeReq;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	chk_take_needs_gie: assert property (@(posedge clk) disable iff (!nrst) // [RULE_06]
		irqTake |-> $past(s.gie))
		else $error("interrupt taken with global enable low");

	chk_take_stack_full: assert property (@(posedge clk) disable iff (!nrst) // [RULE_11]
		irqTake |-> !$past(stackFull))
		else $error("interrupt taken with stack full");

	chk_take_clears_gie: assert property (@(posedge clk) disable iff (!nrst) // [RULE_09]
		irqTake |-> !s.gie ##1 !irqTake)
		else $error("global enable not cleared on service");

	chk_push_pc_value: assert property (@(posedge clk) disable iff (!nrst) // [RULE_07]
		irqTake |-> pushReq && (pushPc == $past(nextPc)))
		else $error("pushed address differs from next pc");

	chk_vector_range: assert property (@(posedge clk) disable iff (!nrst) // [RULE_14]
		irqTake |-> (irqVector >= mic_pkg::VEC_BASE) && (irqVector <= mic_pkg::VEC_LAST)
			&& (irqVector[1:0] == 2'b00))
		else $error("vector outside table");

	chk_prio_mf0_order: assert property (@(posedge clk) disable iff (!nrst) // [RULE_13]
		(irqTake && irqVector == mic_pkg::VEC_MF0) |-> ($past(pending[2:0]) == 3'b000))
		else $error("lower priority taken over higher");

	chk_disabled_no_jump: assert property (@(posedge clk) disable iff (!nrst) // [RULE_05]
		!s.en[mic_pkg::SRC_EXT0] |=> !(irqTake && irqVector == mic_pkg::VEC_BASE))
		else $error("jump taken for disabled source");

	chk_event_sets_flag: assert property (@(posedge clk) disable iff (!nrst) // [RULE_04]
		srcEvent[3] |=> s.flag[mic_pkg::SRC_TB0])
		else $error("event did not set its flag");

	chk_mf_or_flags: assert property (@(posedge clk) disable iff (!nrst) // [RULE_19]
		(s.tmrFlag[1] && s.tmrEn[1] && !s.dpWrite) |=> s.flag[mic_pkg::SRC_MF0])
		else $error("multi-function flag missed enabled compare flag");

	chk_sub_flag_kept: assert property (@(posedge clk) disable iff (!nrst) // [RULE_20]
		(irqTake && $past(s.tmrFlag[0]) && !$past(s.dpWrite)) |-> s.tmrFlag[0])
		else $error("compare flag cleared by service");

	chk_reserved_zero: assert property (@(posedge clk) disable iff (!nrst) // [RULE_03]
		$past(rdMfiReq) |-> (hrdata[7:6] == 2'b00) && (hrdata[3:2] == 2'b00))
		else $error("reserved timer control bits not zero");

	chk_wake_on_flag: assert property (@(posedge clk) disable iff (!nrst) // [RULE_15]
		(sleepMode && srcEvent[0] && !s.flag[mic_pkg::SRC_EXT0]) |=> wakeReq)
		else $error("no wake on new flag in sleep");

	chk_return_pops: assert property (@(posedge clk) disable iff (!nrst) // [RULE_08]
		returnExec |=> popReq)
		else $error("return did not pop");

endmodule

// ---- testbench/mic_cpu_model.sv ----
// Core sequencer and return stack facing the interrupt controller
`timescale 1ns/1ps

module mic_cpu_model #(
	parameter int DEPTH = 1
) (
	input  wire logic                     clk,
	input  wire logic                     nrst,
	input  wire logic                     irqTake,
	input  wire logic [7:0]               irqVector,
	input  wire logic                     pushReq,
	input  wire logic [mic_pkg::PC_W-1:0] pushPc,
	input  wire logic                     popReq,
	input  wire logic                     returnCmd,
	input  wire logic                     hold,
	output logic [mic_pkg::PC_W-1:0]      nextPc,
	output logic                          cpuReady,
	output logic                          stackFull,
	output logic                          returnExec,
	output logic [mic_pkg::PC_W-1:0]      topPc
);
	logic [mic_pkg::PC_W-1:0] pc;
	logic [mic_pkg::PC_W-1:0] stk [DEPTH];
	int                       sp;

	// ---------------------------------------------------------------
	// Program counter and stack
	// ---------------------------------------------------------------
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pc <= 13'h0100;
			sp <= 0;
			returnExec <= 1'b0;
		end else begin
			returnExec <= returnCmd;
			if (pushReq && sp < DEPTH) begin
				stk[sp] <= pushPc;
				sp <= sp + 1;
			end
			if (irqTake) begin
				pc <= {5'h00, irqVector};
			end else if (popReq && sp > 0) begin
				pc <= stk[sp-1];
				sp <= sp - 1;
			end else begin
				pc <= pc + 13'h0001;
			end
		end
	end

	// Stall only on request, to mimic a long multi-cycle instruction
	assign cpuReady  = !hold;
	assign nextPc    = pc;
	assign stackFull = (sp == DEPTH);
	assign topPc     = (sp > 0) ? stk[sp-1] : 13'h0000;
endmodule

// ---- testbench/mic_irq_ctrl_tb.sv ----
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps

module mic_irq_ctrl_tb;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [8:0]  srcEvent = 9'h000;
	logic [3:0]  tmrEvent = 4'h0;
	logic        sleepMode = 1'b0;
	logic        returnCmd = 1'b0;
	logic        hold = 1'b0;
	logic [31:0] hrdata, rd;
	logic        hreadyout, hresp, irqTake, pushReq, popReq, wakeReq;
	logic        cpuReady, stackFull, returnExec;
	logic [7:0]  irqVector, lastVec;
	logic [12:0] nextPc, pushPc, topPc, prevNp, lastPush;
	int          n_fail = 0;
	int          n_tests = 0;
	int          takeCnt = 0;
	int          nTake = 0;

	always #20 clk = ~clk;

	mic_irq_ctrl mic_irq_ctrl_inst (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .srcEvent(srcEvent),
		.tmrEvent(tmrEvent), .nextPc(nextPc), .cpuReady(cpuReady), .stackFull(stackFull),
		.returnExec(returnExec), .sleepMode(sleepMode), .irqTake(irqTake),
		.irqVector(irqVector), .pushReq(pushReq), .pushPc(pushPc), .popReq(popReq),
		.wakeReq(wakeReq));

	mic_cpu_model #(.DEPTH(1)) mic_cpu_model_inst (.clk(clk), .nrst(nrst), .irqTake(irqTake),
		.irqVector(irqVector), .pushReq(pushReq), .pushPc(pushPc), .popReq(popReq),
		.returnCmd(returnCmd), .hold(hold), .nextPc(nextPc), .cpuReady(cpuReady),
		.stackFull(stackFull), .returnExec(returnExec), .topPc(topPc));

	// ---------------------------------------------------------------
	// Checking and closing
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic results;
		if (n_fail == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Takes are counted here so no pulse is missed while the bus is busy
	always @(posedge clk) begin
		prevNp <= nextPc;
		if (irqTake === 1'b1) begin
			takeCnt <= takeCnt + 1;
			lastVec <= irqVector;
			lastPush <= pushPc;
			chk("push strobe", 32'h0000_0001, {31'h0000_0000, pushReq});
			chk("pushed pc", {19'h0_0000, prevNp}, {19'h0_0000, pushPc});
		end
		if (popReq === 1'b1) begin
			chk("popped pc", {19'h0_0000, lastPush}, {19'h0_0000, topPc});
		end
	end

	// ---------------------------------------------------------------
	// Bus and stimulus tasks
	// ---------------------------------------------------------------
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic waitReady;
		int i;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (hreadyout !== 1'b1 && i < 20);
		if (hreadyout !== 1'b1) begin
			n_fail++;
			results();
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h00_0000, a};
		waitReady();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h00_0000, d};
		waitReady();
		rd = hrdata;
		chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(nm, {24'h00_0000, e}, rd);
	endtask

	task automatic ev(input logic [8:0] s, input logic [3:0] t);
		@(posedge clk);
		srcEvent <= s;
		tmrEvent <= t;
		@(posedge clk);
		srcEvent <= 9'h000;
		tmrEvent <= 4'h0;
	endtask

	task automatic waitTake(input logic [7:0] v);
		int i;
		i = 0;
		while (takeCnt == nTake && i < 60) begin
			@(posedge clk);
			i++;
		end
		if (takeCnt == nTake) begin
			n_fail++;
			results();
		end
		nTake++;
		chk("vector", {24'h00_0000, v}, {24'h00_0000, lastVec});
	endtask

	task automatic noTake(input int n);
		idle(n);
		chk("take count", nTake, takeCnt);
	endtask

	task automatic doReturn;
		int i;
		@(posedge clk);
		returnCmd <= 1'b1;
		@(posedge clk);
		returnCmd <= 1'b0;
		i = 0;
		while (popReq !== 1'b1 && i < 20) begin
			@(posedge clk);
			i++;
		end
		if (popReq !== 1'b1) begin
			n_fail++;
			results();
		end
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	initial begin
		idle(6);
		nrst <= 1'b1;
		idle(2);
		for (int a = 0; a <= 24; a += 4) rdc("reset value", 8'(a), 8'h00);
		wr(8'h18, 8'hFF);
		rdc("unmapped", 8'h18, 8'h00);
		wr(mic_pkg::OFS_TMR0, 8'hFF);
		wr(mic_pkg::OFS_TMR1, 8'hFF);
		rdc("timer0 ctrl", mic_pkg::OFS_TMR0, 8'h33);
		rdc("timer1 ctrl", mic_pkg::OFS_TMR1, 8'h33);
		rdc("merged flags", mic_pkg::OFS_CTRL1, 8'h30);
		wr(mic_pkg::OFS_TMR0, 8'h00);
		wr(mic_pkg::OFS_TMR1, 8'h00);
		wr(mic_pkg::OFS_CTRL1, 8'h00);
		// Flag without enable, then enable without global enable
		ev(9'h001, 4'h0);
		rdc("ext0 flag", mic_pkg::OFS_CTRL0, 8'h10);
		wr(mic_pkg::OFS_CTRL0, 8'h11);
		noTake(8);
		wr(mic_pkg::OFS_CTRL0, 8'h12);
		noTake(8);
		@(posedge clk);
		hold <= 1'b1;
		wr(mic_pkg::OFS_CTRL0, 8'h13);
		noTake(6);
		hold <= 1'b0;
		waitTake(8'h04);
		rdc("after take", mic_pkg::OFS_CTRL0, 8'h02);
		doReturn();
		wr(mic_pkg::OFS_CTRL0, 8'h00);
		// Wake from sleep, and a flag set beforehand that must not wake
		@(posedge clk);
		sleepMode <= 1'b1;
		ev(9'h109, 4'h0);
		idle(2);
		chk("wake", 32'h0000_0001, {31'h0000_0000, wakeReq});
		bus(1'b0, mic_pkg::OFS_STAT, 8'h00);
		chk("wake status", 32'h0000_0001, {31'h0000_0000, rd[8]});
		sleepMode <= 1'b0;
		idle(2);
		chk("wake clear", 32'h0000_0000, {31'h0000_0000, wakeReq});
		sleepMode <= 1'b1;
		ev(9'h100, 4'h0);
		idle(2);
		chk("no wake", 32'h0000_0000, {31'h0000_0000, wakeReq});
		sleepMode <= 1'b0;
		// All eleven sources pending at once
		wr(mic_pkg::OFS_CTRL1, 8'hFF);
		wr(mic_pkg::OFS_CTRL2, 8'hFF);
		wr(mic_pkg::OFS_CTRL0, 8'h7F);
		for (int i = 0; i < 11; i++) begin
			waitTake(8'h04 + 8'(4 * i));
			bus(1'b0, mic_pkg::OFS_CTRL0, 8'h00);
			chk("global enable", 32'h0000_0000, {31'h0000_0000, rd[0]});
			chk("no nesting", nTake, takeCnt);
			doReturn();
		end
		rdc("ctrl0 cleared", mic_pkg::OFS_CTRL0, 8'h0F);
		rdc("ctrl1 cleared", mic_pkg::OFS_CTRL1, 8'h0F);
		rdc("ctrl2 cleared", mic_pkg::OFS_CTRL2, 8'h0F);
		wr(mic_pkg::OFS_CTRL0, 8'h00);
		wr(mic_pkg::OFS_CTRL1, 8'h00);
		wr(mic_pkg::OFS_CTRL2, 8'h00);
		// Full stack holds off a re-enabled request until the pop
		wr(mic_pkg::OFS_CTRL0, 8'h5B);
		waitTake(8'h04);
		wr(mic_pkg::OFS_CTRL0, 8'h4B);
		noTake(8);
		bus(1'b0, mic_pkg::OFS_STAT, 8'h00);
		chk("last vector", 32'h0000_0004, {24'h00_0000, rd[7:0]});
		doReturn();
		waitTake(8'h0C);
		doReturn();
		wr(mic_pkg::OFS_CTRL0, 8'h00);
		// Timer compare matches: timer0 on P, timer1 on A
		for (int t = 0; t < 2; t++) begin
			wr(t ? mic_pkg::OFS_TMR1 : mic_pkg::OFS_TMR0, t ? 8'h02 : 8'h01);
			wr(mic_pkg::OFS_CTRL1, t ? 8'h02 : 8'h01);
			wr(mic_pkg::OFS_CTRL0, 8'h01);
			ev(9'h000, t ? 4'h8 : 4'h1);
			waitTake(t ? 8'h14 : 8'h10);
			rdc("timer flag kept", t ? mic_pkg::OFS_TMR1 : mic_pkg::OFS_TMR0,
				t ? 8'h22 : 8'h11);
			wr(t ? mic_pkg::OFS_TMR1 : mic_pkg::OFS_TMR0, t ? 8'h02 : 8'h01);
			wr(mic_pkg::OFS_CTRL1, 8'h00);
			doReturn();
			noTake(6);
		end
		wr(mic_pkg::OFS_CTRL0, 8'h00);
		results();
	end
endmodule
